//--- pint_pkg.sv
// Constants, register map and types for the pin interrupt engine
`default_nettype none
package pint_pkg;
  localparam int unsigned NCH   = 8;
  localparam int unsigned NPINS = 64;
  localparam int unsigned SEL_W = 6;

  // Pins that cannot be routed into the engine
  localparam logic [5:0] EXCL_PIN_A = 6'h28;
  localparam logic [5:0] EXCL_PIN_B = 6'h37;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_RISE_EN  = 8'h04;
  localparam logic [7:0] OFS_FALL_EN  = 8'h08;
  localparam logic [7:0] OFS_RISE_ST  = 8'h0c;
  localparam logic [7:0] OFS_FALL_ST  = 8'h10;
  localparam logic [7:0] OFS_REQ_ST   = 8'h14;
  localparam logic [7:0] OFS_PM_CTRL  = 8'h18;
  localparam logic [7:0] OFS_PM_SRC   = 8'h1c;
  localparam logic [7:0] OFS_PM_CFG   = 8'h20;
  localparam logic [7:0] OFS_PIN_SEL0 = 8'h24;
  localparam logic [7:0] OFS_PIN_SEL1 = 8'h28;
  localparam logic [7:0] OFS_IRQ_ST   = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // Field positions
  localparam int unsigned PM_EN_BIT   = 0;
  localparam int unsigned PM_EV_BIT   = 1;
  localparam int unsigned PM_ENDP_LSB = 24;

  // Values after reset
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [1:0]  RST_CTRL  = 2'h0;
  localparam logic [23:0] RST_SRC   = 24'hfac688;
  localparam logic [31:0] RST_CFG   = 32'h00000000;
  localparam logic [47:0] RST_SEL   = 48'h000000000000;
  localparam logic [15:0] RST_HALF  = 16'h0000;
  localparam logic [31:0] RST_WORD  = 32'h00000000;

  typedef enum logic [2:0] {
    COND_ALWAYS      = 3'b000,
    COND_STICKY_RISE = 3'b001,
    COND_STICKY_FALL = 3'b010,
    COND_STICKY_EDGE = 3'b011,
    COND_HIGH        = 3'b100,
    COND_LOW         = 3'b101,
    COND_NEVER       = 3'b110,
    COND_EDGE_NOW    = 3'b111
  } cond_type;

  function automatic logic [2:0] field3(input logic [23:0] v,
                                        input int unsigned k);
    return v[3*k +: 3];
  endfunction

  function automatic logic [5:0] field6(input logic [47:0] v,
                                        input int unsigned k);
    return v[6*k +: 6];
  endfunction
endpackage
`default_nettype wire

//--- pin_sync_edge.sv
// Two-stage synchroniser with edge detection for eight inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] raw,
  output logic      [7:0] level,
  output logic      [7:0] rise,
  output logic      [7:0] fall
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] s1_d;
  logic [7:0] s2_d;
  logic [7:0] s3_d;

  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_q <= pint_pkg::RST_BYTE;
      s2_q <= pint_pkg::RST_BYTE;
      s3_q <= pint_pkg::RST_BYTE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Edges only from the settled stages, one pulse per edge
  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;
endmodule
`default_nettype wire

//--- pin_interrupt_pattern_match.sv
// Pin interrupt and pattern match engine with AHB-Lite registers
// Notes on behaviour
// - Eight channels pick pins, two excluded
// - Each channel has its own request line
// - Edge channels fire on rise, fall, both
// - Level channels follow high or low level
// - Pin requests raise the wake output
// - Pattern slices test levels and transitions
// - Each product term has its own request
// - Optional receive-event pulse on matches
// - Pattern matches never raise wake
// - Register accesses finish without wait states
`timescale 1ns/100ps
`default_nettype none
module pin_interrupt_pattern_match (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [63:0] pin_in,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  chan_irq,
  output logic             irq,
  output logic             cpu_receive_event,
  output logic             wake_request
);
  logic [7:0]  mode_q, mode_d, rise_en_q, rise_en_d, fall_en_q, fall_en_d;
  logic [7:0]  rise_st_q, rise_st_d, fall_st_q, fall_st_d;
  logic [1:0]  pm_ctrl_q, pm_ctrl_d;
  logic [23:0] pm_src_q, pm_src_d;
  logic [31:0] pm_cfg_q, pm_cfg_d;
  logic [47:0] pin_sel_q, pin_sel_d;
  logic [15:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic [7:0]  sticky_q, sticky_d, term_q, term_d;
  logic [7:0]  chan_irq_q, chan_irq_d;
  logic        irq_q, irq_d, cpu_receive_event_q, cpu_receive_event_d, wake_q, wake_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q, hresp_q;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;

  logic [7:0]  raw_sel, lvl, rise_p, fall_p, req;
  logic [7:0]  s_lvl, s_rise, s_fall, s_true, consumed;
  logic        pm_en, a_ok;

  assign pm_en = pm_ctrl_q[pint_pkg::PM_EN_BIT];
  assign a_ok  = hsel & htrans[1] & hready;

  // Excluded pins read as a constant low
  always_comb begin
    raw_sel = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (pint_pkg::field6(pin_sel_q, k) != pint_pkg::EXCL_PIN_A &&
          pint_pkg::field6(pin_sel_q, k) != pint_pkg::EXCL_PIN_B) begin
        raw_sel[k] = pin_in[pint_pkg::field6(pin_sel_q, k)];
      end
    end
  end

  pin_sync_edge u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .raw      (raw_sel),
    .level    (lvl),
    .rise     (rise_p),
    .fall     (fall_p)
  );

  // Pattern slices and product terms
  always_comb begin
    logic       acc;
    logic [7:0] seg;
    logic [7:0] sticky_eff;
    acc        = 1'b1;
    seg        = 8'h00;
    sticky_eff = 8'h00;
    s_lvl      = 8'h00;
    s_rise     = 8'h00;
    s_fall     = 8'h00;
    s_true     = 8'h00;
    term_d     = 8'h00;
    consumed   = 8'h00;
    for (int k = 0; k < 8; k++) begin
      s_lvl[k]  = lvl[pint_pkg::field3(pm_src_q, k)];
      s_rise[k] = rise_p[pint_pkg::field3(pm_src_q, k)];
      s_fall[k] = fall_p[pint_pkg::field3(pm_src_q, k)];
    end
    for (int k = 0; k < 8; k++) begin
      sticky_eff[k] = sticky_q[k] | s_rise[k] | s_fall[k];
      case (pint_pkg::cond_type'(pint_pkg::field3(pm_cfg_q[23:0], k)))
        pint_pkg::COND_ALWAYS:      s_true[k] = 1'b1;
        pint_pkg::COND_STICKY_RISE: s_true[k] = sticky_q[k] | s_rise[k];
        pint_pkg::COND_STICKY_FALL: s_true[k] = sticky_q[k] | s_fall[k];
        pint_pkg::COND_STICKY_EDGE: s_true[k] = sticky_eff[k];
        pint_pkg::COND_HIGH:        s_true[k] = s_lvl[k];
        pint_pkg::COND_LOW:         s_true[k] = ~s_lvl[k];
        pint_pkg::COND_NEVER:       s_true[k] = 1'b0;
        default:                    s_true[k] = s_rise[k] | s_fall[k];
      endcase
      acc    = acc & s_true[k];
      seg[k] = 1'b1;
      if (pm_cfg_q[pint_pkg::PM_ENDP_LSB + k] || k == 7) begin
        term_d[k] = acc & pm_en;
        if (acc) begin
          consumed = consumed | seg;
        end
        acc = 1'b1;
        seg = 8'h00;
      end
    end
  end

  // Sticky slices remember only the edge their condition wants
  always_comb begin
    sticky_d = 8'h00;
    for (int k = 0; k < 8; k++) begin
      case (pint_pkg::cond_type'(pint_pkg::field3(pm_cfg_q[23:0], k)))
        pint_pkg::COND_STICKY_RISE: sticky_d[k] = sticky_q[k] | s_rise[k];
        pint_pkg::COND_STICKY_FALL: sticky_d[k] = sticky_q[k] | s_fall[k];
        pint_pkg::COND_STICKY_EDGE:
          sticky_d[k] = sticky_q[k] | s_rise[k] | s_fall[k];
        default:                    sticky_d[k] = 1'b0;
      endcase
    end
    sticky_d = sticky_d & ~consumed;
    if (wr_pend_q && wr_addr_q == pint_pkg::OFS_PM_CFG) begin
      sticky_d = 8'h00;
    end
  end

  // Channel requests, status flags and outputs
  always_comb begin
    logic       we;
    logic [7:0] ev;
    we = wr_pend_q;
    ev = 8'h00;
    mode_d     = mode_q;
    rise_en_d  = rise_en_q;
    fall_en_d  = fall_en_q;
    pm_ctrl_d  = pm_ctrl_q;
    pm_src_d   = pm_src_q;
    pm_cfg_d   = pm_cfg_q;
    pin_sel_d  = pin_sel_q;
    irq_mask_d = irq_mask_q;
    rise_st_d  = rise_st_q;
    fall_st_d  = fall_st_q;
    irq_st_d   = irq_st_q;
    if (we) begin
      if (wr_addr_q == pint_pkg::OFS_MODE) begin
        mode_d = hwdata[7:0];
      end else if (wr_addr_q == pint_pkg::OFS_RISE_EN) begin
        rise_en_d = hwdata[7:0];
      end else if (wr_addr_q == pint_pkg::OFS_FALL_EN) begin
        fall_en_d = hwdata[7:0];
      end else if (wr_addr_q == pint_pkg::OFS_RISE_ST) begin
        rise_st_d = rise_st_q & ~hwdata[7:0];
      end else if (wr_addr_q == pint_pkg::OFS_FALL_ST) begin
        fall_st_d = fall_st_q & ~hwdata[7:0];
      end else if (wr_addr_q == pint_pkg::OFS_PM_CTRL) begin
        pm_ctrl_d = hwdata[1:0];
      end else if (wr_addr_q == pint_pkg::OFS_PM_SRC) begin
        pm_src_d = hwdata[23:0];
      end else if (wr_addr_q == pint_pkg::OFS_PM_CFG) begin
        pm_cfg_d = hwdata;
      end else if (wr_addr_q == pint_pkg::OFS_PIN_SEL0) begin
        pin_sel_d[23:0] = hwdata[23:0];
      end else if (wr_addr_q == pint_pkg::OFS_PIN_SEL1) begin
        pin_sel_d[47:24] = hwdata[23:0];
      end else if (wr_addr_q == pint_pkg::OFS_IRQ_ST) begin
        irq_st_d = irq_st_q & ~hwdata[15:0];
      end else if (wr_addr_q == pint_pkg::OFS_IRQ_MASK) begin
        irq_mask_d = hwdata[15:0];
      end
    end
    // Set after clear, so an edge in the clearing cycle survives
    rise_st_d = rise_st_d | (rise_p & ~mode_q & rise_en_q);
    fall_st_d = fall_st_d | (fall_p & ~mode_q & fall_en_q);
    req = (~mode_q & (rise_st_q | fall_st_q)) |
          (mode_q & rise_en_q & ~(lvl ^ fall_en_q));
    chan_irq_d = pm_en ? term_d : req;
    ev = chan_irq_d & ~chan_irq_q;
    irq_st_d = irq_st_d | (pm_en ? {ev, 8'h00} : {8'h00, ev});
    irq_d  = |(irq_st_d & irq_mask_d);
    cpu_receive_event_d = pm_ctrl_q[pint_pkg::PM_EV_BIT] &
             (|(term_d & ~term_q));
    // Wake comes only from plain pin channels
    wake_d = ~pm_en & (|req);
  end

  // Bus slave: zero wait states, read data from next-state values
  always_comb begin
    logic [7:0] ra;
    ra        = haddr[7:0];
    wr_pend_d = a_ok & hwrite;
    wr_addr_d = haddr[7:0];
    hrdata_d  = 32'h00000000;
    if (a_ok && !hwrite) begin
      if (ra == pint_pkg::OFS_MODE) begin
        hrdata_d = {24'h000000, mode_d};
      end else if (ra == pint_pkg::OFS_RISE_EN) begin
        hrdata_d = {24'h000000, rise_en_d};
      end else if (ra == pint_pkg::OFS_FALL_EN) begin
        hrdata_d = {24'h000000, fall_en_d};
      end else if (ra == pint_pkg::OFS_RISE_ST) begin
        hrdata_d = {24'h000000, rise_st_d};
      end else if (ra == pint_pkg::OFS_FALL_ST) begin
        hrdata_d = {24'h000000, fall_st_d};
      end else if (ra == pint_pkg::OFS_REQ_ST) begin
        hrdata_d = {24'h000000, chan_irq_d};
      end else if (ra == pint_pkg::OFS_PM_CTRL) begin
        hrdata_d = {30'h00000000, pm_ctrl_d};
      end else if (ra == pint_pkg::OFS_PM_SRC) begin
        hrdata_d = {8'h00, pm_src_d};
      end else if (ra == pint_pkg::OFS_PM_CFG) begin
        hrdata_d = pm_cfg_d;
      end else if (ra == pint_pkg::OFS_PIN_SEL0) begin
        hrdata_d = {8'h00, pin_sel_d[23:0]};
      end else if (ra == pint_pkg::OFS_PIN_SEL1) begin
        hrdata_d = {8'h00, pin_sel_d[47:24]};
      end else if (ra == pint_pkg::OFS_IRQ_ST) begin
        hrdata_d = {16'h0000, irq_st_d};
      end else if (ra == pint_pkg::OFS_IRQ_MASK) begin
        hrdata_d = {16'h0000, irq_mask_d};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q      <= pint_pkg::RST_BYTE;
      rise_en_q   <= pint_pkg::RST_BYTE;
      fall_en_q   <= pint_pkg::RST_BYTE;
      rise_st_q   <= pint_pkg::RST_BYTE;
      fall_st_q   <= pint_pkg::RST_BYTE;
      pm_ctrl_q   <= pint_pkg::RST_CTRL;
      pm_src_q    <= pint_pkg::RST_SRC;
      pm_cfg_q    <= pint_pkg::RST_CFG;
      pin_sel_q   <= pint_pkg::RST_SEL;
      irq_st_q    <= pint_pkg::RST_HALF;
      irq_mask_q  <= pint_pkg::RST_HALF;
      sticky_q    <= pint_pkg::RST_BYTE;
      term_q      <= pint_pkg::RST_BYTE;
      chan_irq_q  <= pint_pkg::RST_BYTE;
      irq_q       <= 1'b0;
      cpu_receive_event_q      <= 1'b0;
      wake_q      <= 1'b0;
      hrdata_q    <= pint_pkg::RST_WORD;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= pint_pkg::RST_BYTE;
    end else begin
      mode_q      <= mode_d;
      rise_en_q   <= rise_en_d;
      fall_en_q   <= fall_en_d;
      rise_st_q   <= rise_st_d;
      fall_st_q   <= fall_st_d;
      pm_ctrl_q   <= pm_ctrl_d;
      pm_src_q    <= pm_src_d;
      pm_cfg_q    <= pm_cfg_d;
      pin_sel_q   <= pin_sel_d;
      irq_st_q    <= irq_st_d;
      irq_mask_q  <= irq_mask_d;
      sticky_q    <= sticky_d;
      term_q      <= term_d;
      chan_irq_q  <= chan_irq_d;
      irq_q       <= irq_d;
      cpu_receive_event_q      <= cpu_receive_event_d;
      wake_q      <= wake_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
    end
  end

  assign hrdata            = hrdata_q;
  assign hreadyout         = hreadyout_q;
  assign hresp             = hresp_q;
  assign chan_irq          = chan_irq_q;
  assign irq               = irq_q;
  assign cpu_receive_event = cpu_receive_event_q;
  assign wake_request      = wake_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_pin_exclude: assert property (
    pint_pkg::field6(pin_sel_q, 7) == pint_pkg::EXCL_PIN_A |-> !raw_sel[7])
    else $error("excluded pin reached channel 7");
  a_own_lines: assert property (
    !pm_en && mode_q == 8'h00
    |=> chan_irq_q == ($past(rise_st_q) | $past(fall_st_q)))
    else $error("request leaked onto another channel line");
  a_edge_request: assert property (
    !pm_en && !wr_pend_q &&
    ((rise_p & ~mode_q & rise_en_q) | (fall_p & ~mode_q & fall_en_q)) != 0
    |=> (rise_st_q | fall_st_q) != 8'h00 ##1 (chan_irq_q & ~mode_q) != 8'h00)
    else $error("enabled edge did not raise its request");
  a_level_follow: assert property (
    !pm_en && !wr_pend_q && mode_q[0] && rise_en_q[0] &&
    (lvl[0] == fall_en_q[0]) |=> chan_irq_q[0])
    else $error("level channel missed its active level");
  a_wake_raise: assert property (
    !pm_en && !wr_pend_q && req != 8'h00 |=> wake_request)
    else $error("pin request did not raise wake");
  a_pm_slice_high: assert property (
    pm_en && !wr_pend_q && s_lvl[1:0] == 2'h3 &&
    pm_cfg_q[5:0] == {pint_pkg::COND_HIGH, pint_pkg::COND_HIGH} &&
    pm_cfg_q[pint_pkg::PM_ENDP_LSB + 1] |=> chan_irq_q[1])
    else $error("two high slices term did not match");
  a_pm_term_irq: assert property (
    pm_en && term_d != 8'h00 |=> chan_irq_q == $past(term_d))
    else $error("product term request line wrong");
  a_pm_event: assert property (
    pm_ctrl_q == 2'h3 && (term_d & ~term_q) != 8'h00
    |=> cpu_receive_event && term_q != 8'h00)
    else $error("pattern match did not pulse receive event");
  a_pm_no_wake: assert property (
    pm_en && !wr_pend_q |=> !wake_request)
    else $error("pattern match raised wake");
  a_bus_write: assert property (
    a_ok && hwrite && haddr[7:0] == pint_pkg::OFS_IRQ_MASK
    |=> hreadyout ##1 irq_mask_q == $past(hwdata[15:0], 1))
    else $error("register write not complete in one cycle");
  a_one_pulse: assert property (
    rise_p != 8'h00 |=> (rise_p & $past(rise_p)) == 8'h00)
    else $error("one edge gave two rise pulses");
endmodule
`default_nettype wire

//--- interrupt_sink_model.sv
// Behavioural interrupt controller and event input seen by the engine
`timescale 1ns/100ps
`default_nettype none
module interrupt_sink_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] chan_irq,
  input  wire logic       cpu_receive_event,
  output logic      [7:0] events_q,
  output logic      [7:0] seen_q
);
  // Counts event pulses; a stuck-high event shows as a runaway count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      events_q <= 8'h00;
      seen_q   <= 8'h00;
    end else begin
      events_q <= events_q + {7'h00, cpu_receive_event};
      seen_q   <= seen_q | chan_irq;
    end
  end
endmodule
`default_nettype wire

//--- pin_interrupt_pattern_match_bench.sv
// Self-checking bench for the pin interrupt and pattern match engine
`timescale 1ns/100ps
`default_nettype none
module pin_interrupt_pattern_match_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [63:0] pin_in = 64'h0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  chan_irq;
  logic        irq;
  logic        cpu_receive_event;
  logic        wake_request;
  logic [7:0]  events_q;
  logic [7:0]  seen_q;
  logic [31:0] rd_smp;
  logic        rdy_smp;
  logic [31:0] rnd = 32'hb486f423;
  logic [31:0] cfg;
  logic [47:0] sel;
  logic [7:0]  pins;
  logic [7:0]  pol;
  logic [7:0]  base;
  int          fail_count = 0;
  int          comparisons = 0;

  always #2.5 core_clk = ~core_clk;

  // Bus values captured at the edge itself, free of update races
  always @(posedge core_clk) begin
    rd_smp  <= hrdata;
    rdy_smp <= hreadyout;
  end

  pin_interrupt_pattern_match dut (
    .core_clk(core_clk), .reset(reset), .pin_in(pin_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan_irq(chan_irq),
    .irq(irq), .cpu_receive_event(cpu_receive_event),
    .wake_request(wake_request)
  );

  interrupt_sink_model sink (
    .core_clk(core_clk), .reset(reset), .chan_irq(chan_irq),
    .cpu_receive_event(cpu_receive_event), .events_q(events_q),
    .seen_q(seen_q)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Level request: high-active where polarity bit set
  function automatic logic [7:0] lvl_exp(input logic [7:0] p,
                                         input logic [7:0] hi);
    return ~(p ^ hi);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ready(output logic [31:0] n);
    n = 32'h0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (rdy_smp !== 1'b1 && n < 32'h14);
    if (rdy_smp !== 1'b1) begin
      fail_count++;
      end_sim;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    logic [31:0] n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready(n);
    check(n, 32'h1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n);
    rdat = rd_smp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, e);
  endtask

  // Pins settle through the synchroniser well inside five edges
  task automatic drive(input logic [7:0] p);
    pin_in[15:8] <= p;
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  initial begin
    for (int k = 0; k < 8; k++) begin
      sel[6*k +: 6] = 6'(8 + k);
    end
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check(32'(chan_irq), 32'h0);
    check(32'({hreadyout, hresp, irq, wake_request}), 32'h8);
    rchk(pint_pkg::OFS_PM_SRC, {8'h0, pint_pkg::RST_SRC});
    rchk(pint_pkg::OFS_MODE, 32'h0);
    wr(8'h40, 32'hffffffff);
    rchk(8'h40, 32'h0);
    wr(pint_pkg::OFS_PIN_SEL0, sel[31:0]);
    wr(pint_pkg::OFS_PIN_SEL1, {8'h0, sel[47:24]});
    rchk(pint_pkg::OFS_PIN_SEL1, {8'h0, sel[47:24]});
    $display("Test reset and map done");

    wr(pint_pkg::OFS_RISE_EN, 32'hff);
    wr(pint_pkg::OFS_FALL_EN, 32'h0f);
    drive(8'hff);
    check(32'(chan_irq), 32'hff);
    check(32'(wake_request), 32'h1);
    rchk(pint_pkg::OFS_FALL_ST, 32'h0);
    check(32'(irq), 32'h0);
    wr(pint_pkg::OFS_IRQ_MASK, 32'h01);
    rchk(pint_pkg::OFS_IRQ_ST, 32'hff);
    check(32'(irq), 32'h1);
    wr(pint_pkg::OFS_RISE_ST, 32'hff);
    rchk(pint_pkg::OFS_RISE_ST, 32'h0);
    wr(pint_pkg::OFS_IRQ_ST, 32'hff);
    rchk(pint_pkg::OFS_IRQ_ST, 32'h0);
    check(32'({irq, chan_irq}), 32'h0);
    drive(8'h00);
    check(32'(chan_irq), 32'h0f);
    rchk(pint_pkg::OFS_FALL_ST, 32'h0f);
    check(32'(seen_q), 32'hff);
    wr(pint_pkg::OFS_FALL_ST, 32'hff);
    $display("Test edge channels done");

    wr(pint_pkg::OFS_MODE, 32'hff);
    for (int i = 0; i < 14; i++) begin
      rnd = xs(rnd);
      pol = (i == 0) ? 8'hff : rnd[7:0];
      pins = (i == 0) ? 8'h00 : rnd[15:8];
      wr(pint_pkg::OFS_FALL_EN, {24'h0, pol});
      drive(pins);
      check(32'(chan_irq), 32'(lvl_exp(pins, pol)));
      check(32'(wake_request), 32'(|lvl_exp(pins, pol)));
    end
    // Excluded pin reads low, so a low-active channel on it requests
    wr(pint_pkg::OFS_FALL_EN, 32'h0);
    wr(pint_pkg::OFS_PIN_SEL1, {8'h0, pint_pkg::EXCL_PIN_A, sel[41:24]});
    pin_in[40] <= 1'b1;
    drive(8'hff);
    check(32'(chan_irq), 32'h80);
    wr(pint_pkg::OFS_PIN_SEL1, {8'h0, sel[47:24]});
    $display("Test level channels done");

    wr(pint_pkg::OFS_MODE, 32'h0);
    wr(pint_pkg::OFS_RISE_EN, 32'h0);
    drive(8'h00);
    wr(pint_pkg::OFS_IRQ_ST, 32'hffff);
    // Term 1 is slice 0 high and slice 1 high; rest never match
    cfg = 32'h02000024;
    for (int k = 2; k < 8; k++) begin
      cfg[3*k +: 3] = pint_pkg::COND_NEVER;
    end
    wr(pint_pkg::OFS_PM_CFG, cfg);
    wr(pint_pkg::OFS_PM_CTRL, 32'h3);
    base = events_q;
    for (int i = 0; i < 6; i++) begin
      pins = 8'(i % 4);
      drive(pins);
      check(32'(chan_irq), {30'h0, &pins[1:0], 1'b0});
      check(32'(wake_request), 32'h0);
    end
    check(32'(events_q), {24'h0, base + 8'h1});
    rchk(pint_pkg::OFS_IRQ_ST, 32'h200);
    wr(pint_pkg::OFS_PM_CTRL, 32'h1);
    drive(8'h03);
    check(32'(chan_irq), 32'h02);
    check(32'(events_q), {24'h0, base + 8'h1});
    // Sticky rise on slice 0 waits for slice 1 high, then is consumed
    drive(8'h00);
    wr(pint_pkg::OFS_IRQ_ST, 32'hffff);
    cfg[5:0] = {pint_pkg::COND_HIGH, pint_pkg::COND_STICKY_RISE};
    wr(pint_pkg::OFS_PM_CFG, cfg);
    drive(8'h01);
    check(32'(chan_irq), 32'h0);
    rchk(pint_pkg::OFS_IRQ_ST, 32'h0);
    drive(8'h03);
    check(32'(chan_irq), 32'h0);
    rchk(pint_pkg::OFS_IRQ_ST, 32'h200);
    $display("Test pattern match done");
    end_sim;
  end
endmodule
`default_nettype wire
